// ===== design/upt_log_lut.sv
// ten times log10 of a code count, in hundredths of a dB
// assumes an 8-bit count; zero yields zero
`timescale 1ns/1ps
module upt_log_lut
(
  input  wire logic [7:0]  n,
  output logic      [15:0] db
);
  import upt_pkg::*;
  // ==========================================================
  // octave times 3.01 dB plus mantissa table
  function automatic logic [15:0] frac_db(input logic [2:0] f);
    case (f)
      3'h0: return 16'h0000;
      3'h1: return 16'h0033;
      3'h2: return 16'h0061;
      3'h3: return 16'h008C;
      3'h4: return 16'h00B0;
      3'h5: return 16'h00D3;
      3'h6: return 16'h00F3;
      default: return 16'h0111;
    endcase
  endfunction
  logic [2:0] e;
  logic [7:0] m;
  always_comb
  begin
    e = 3'h0;
    for (int i = 0; i < 8; i++)
      if (n[i]) e = 3'(i);
    m = n << (3'h7 - e);
    db = 16'(UPT_CDB_OCTAVE * e) + frac_db(m[6:4]);
  end
endmodule // upt_log_lut

// ===== design/upt_pkg.sv
// upstream transmit power and burst profile package
// assumes one clock domain and a classic wishbone master
package upt_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] UPT_OFS_CTRL    = 8'h00;
  localparam logic [7:0] UPT_OFS_CODES   = 8'h04;
  localparam logic [7:0] UPT_OFS_PSEL    = 8'h08;
  localparam logic [7:0] UPT_OFS_PROF_A  = 8'h0C;
  localparam logic [7:0] UPT_OFS_PROF_B  = 8'h10;
  localparam logic [7:0] UPT_OFS_ADJ     = 8'h14;
  localparam logic [7:0] UPT_OFS_REPORT  = 8'h18;
  localparam logic [7:0] UPT_OFS_LIMITS  = 8'h1C;
  localparam logic [7:0] UPT_OFS_TARGET  = 8'h20;
  localparam logic [7:0] UPT_OFS_GRANT   = 8'h24;
  localparam logic [7:0] UPT_OFS_STATUS  = 8'h28;
  localparam logic [7:0] UPT_OFS_SS_IDX  = 8'h2C;
  localparam logic [7:0] UPT_OFS_SS_DATA = 8'h30;
  // ==========================================================
  // sizes and ranges
  localparam int         UPT_NPROF       = 8;
  localparam int         UPT_SS_WORDS    = 48;
  localparam logic [3:0] UPT_SEL_ALL     = 4'hF;
  localparam logic [2:0] UPT_RATE_MAX    = 3'h5;
  localparam logic [7:0] UPT_CODES_MAX   = 8'h80;
  localparam logic [10:0] UPT_PRE_LEN_MAX = 11'h600;
  localparam logic [10:0] UPT_PRE_OFF_MAX = 11'h5FE;
  localparam logic [4:0] UPT_FEC_T_MAX   = 5'h10;
  localparam logic [7:0] UPT_FEC_K_MIN   = 8'h10;
  localparam logic [7:0] UPT_FEC_K_MAX   = 8'hFD;
  localparam logic [5:0] UPT_SS_IDX_LAST = 6'h2F;
  // ==========================================================
  // modulation codes
  localparam logic [2:0] UPT_QPSK   = 3'h0;
  localparam logic [2:0] UPT_QAM8   = 3'h1;
  localparam logic [2:0] UPT_QAM16  = 3'h2;
  localparam logic [2:0] UPT_QAM32  = 3'h3;
  localparam logic [2:0] UPT_QAM64  = 3'h4;
  localparam logic [2:0] UPT_QAM128 = 3'h5;
  // ==========================================================
  // power levels in hundredths of a dB
  localparam logic signed [15:0] UPT_PMIN       = 16'sh1A90;
  localparam logic signed [15:0] UPT_PMAX_CDM   = 16'sh2C24;
  localparam logic signed [15:0] UPT_PMAX_QPSK  = 16'sh2E18;
  localparam logic signed [15:0] UPT_PMAX_Q816  = 16'sh2CEC;
  localparam logic signed [15:0] UPT_PMAX_Q3264 = 16'sh2C88;
  localparam logic signed [15:0] UPT_G_QPSK     = 16'shFF8A;
  localparam logic signed [15:0] UPT_G_Q816     = 16'shFFEB;
  localparam logic signed [15:0] UPT_G_Q128     = 16'sh0005;
  localparam logic signed [15:0] UPT_G_ZERO     = 16'sh0000;
  localparam logic signed [15:0] UPT_PR_RST     = 16'sh2328;
  localparam logic signed [15:0] UPT_LIM_HI_INIT = 16'sh7FFF;
  localparam logic signed [15:0] UPT_LIM_LO_INIT = 16'sh8000;
  localparam logic signed [15:0] UPT_CDB_PER_DB = 16'sh0064;
  localparam logic [15:0]        UPT_CDB_OCTAVE = 16'h012D;
  // ==========================================================
  // types
  typedef enum logic [1:0] {UPT_IDLE, UPT_SCAN, UPT_APPLY} upt_fsm_t;
  typedef struct packed {
    logic cyc; logic stb; logic we; logic [3:0] sel; logic [7:0] adr; logic [31:0] dat;
  } upt_wb_req_t;
  typedef struct packed {logic ack; logic [31:0] dat;} upt_wb_rsp_t;
  typedef struct packed {
    logic [2:0] mod; logic trellis; logic in_use; logic [4:0] fec_t; logic [7:0] fec_k;
    logic [7:0] max_burst; logic [10:0] pre_len; logic [10:0] pre_off;
  } upt_prof_t;
  typedef struct packed {
    logic start; logic [2:0] profile; logic [2:0] rate; logic [7:0] len;
    logic signed [15:0] code_pwr; logic signed [15:0] total_pwr;
  } upt_tx_t;
  // ==========================================================
  // constellation gain relative to 64 QAM
  function automatic logic signed [15:0] upt_gain(input logic [2:0] mod);
    if (mod == UPT_QPSK) return UPT_G_QPSK;
    else if (mod == UPT_QAM8 || mod == UPT_QAM16) return UPT_G_Q816;
    else if (mod == UPT_QAM128) return UPT_G_Q128;
    else return UPT_G_ZERO;
  endfunction
  // upper target power for mode and modulation
  function automatic logic signed [15:0] upt_pmax(input logic cdm, input logic [2:0] mod);
    if (cdm) return UPT_PMAX_CDM;
    else if (mod == UPT_QPSK) return UPT_PMAX_QPSK;
    else if (mod == UPT_QAM8 || mod == UPT_QAM16) return UPT_PMAX_Q816;
    else return UPT_PMAX_Q3264;
  endfunction
endpackage

// ===== design/upt_step_round.sv
// rounds a quarter-dB power command to whole-dB steps
// assumes a signed two's complement command
`timescale 1ns/1ps
module upt_step_round
(
  input  wire logic signed [7:0]  adj_q,
  output logic signed      [15:0] step_cdb
);
  import upt_pkg::*;
  logic [7:0] mag;
  logic [7:0] whole;
  always_comb
  begin
    mag = adj_q[7] ? 8'(-adj_q) : 8'(adj_q);
    whole = 8'((9'(mag) + 9'h001) >> 2);
    step_cdb = 16'($signed({8'h00, whole}) * UPT_CDB_PER_DB);
    if (adj_q[7]) step_cdb = 16'(-step_cdb);
  end
endmodule // upt_step_round

// ===== design/upt_top.sv
// upstream transmit power control and burst profile store
// assumes classic wishbone registers and a mini-slot tick pin
//
// Functional notes
// - code-division upper limit: min over used profiles of pmax minus gain
// - lower limit: max of pmin minus gain plus 10log(active/codes per slot)
// - command: add step, clip to upper limit, then to lower limit
// - spread frame per-code target: reported plus gain minus 10log(active)
// - total frame power is a linear sum of per-code powers
// - unspread frame target: reported plus gain of profile in use
// - target power kept inside pmin and pmax for any code count
// - power steps are whole decibels
// - finer steps round to nearest, exact halves toward the smaller step
// - bursts start at the granted mini-slot
// - only profiles marked in use when granted are transmitted; a grant for any other profile is rejected
// - modulations QPSK to 64 QAM, 128 QAM only with trellis coding
// - preamble length 0 to 1536, offset 0 to 1534
// - block code strength 0 to 16, zero disables coding
// - with coding on, 16 to 253 information bytes
// - maximum burst length field 0 to 255 mini-slots
// - six symbol rates in octaves, chosen per channel
// - channel holds a 1536-bit preamble superstring
// - zero maximum burst length means length comes from the grant
// - time-division uses the same update without the code-count term
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module upt_top
(
  input  wire logic                REF_CLK,
  input  wire logic                RST_N,
  input  wire upt_pkg::upt_wb_req_t WB_REQ,
  output upt_pkg::upt_wb_rsp_t      WB_RSP,
  input  wire logic                MINISLOT_TICK,
  output upt_pkg::upt_tx_t          TX_BURST
);
  import upt_pkg::*;
  // ==========================================================
  // state
  typedef struct packed {
    logic                         ack;
    logic [31:0]                  rdat;
    logic                         cdm;
    logic                         spread_on;
    logic [2:0]                   rate;
    logic [7:0]                   active;
    logic [7:0]                   cpm;
    logic [7:0]                   alloc;
    logic [2:0]                   psel;
    upt_prof_t [UPT_NPROF-1:0]    prof;
    logic [5:0]                   ss_idx;
    logic [UPT_SS_WORDS-1:0][31:0] sstr;
    logic signed [15:0]           pr;
    logic signed [15:0]           step;
    logic signed [15:0]           hi;
    logic signed [15:0]           lo;
    logic                         found;
    upt_fsm_t                     fsm;
    logic [2:0]                   scan;
    logic                         reject;
    logic                         armed;
    logic [15:0]                  gstart;
    logic [7:0]                   glen;
    logic [2:0]                   gprof;
    logic [2:0]                   tick_sync;
    logic                         tick_lvl;
    logic [15:0]                  slot_cnt;
    upt_tx_t                      tx;
  } upt_state_t;

  upt_state_t s_r;
  upt_state_t s_nxt;

  // ==========================================================
  // helpers
  logic [15:0]        l_act;
  logic [15:0]        l_cpm;
  logic [15:0]        l_alc;
  logic signed [15:0] step_in;

  upt_log_lut u_log_act (.n(s_r.active), .db(l_act));
  upt_log_lut u_log_cpm (.n(s_r.cpm),    .db(l_cpm));
  upt_log_lut u_log_alc (.n(s_r.alloc),  .db(l_alc));
  upt_step_round u_round (.adj_q(WB_REQ.dat[7:0]), .step_cdb(step_in));

  function automatic logic signed [15:0] smin(input logic signed [15:0] a, input logic signed [15:0] b);
    return (a < b) ? a : b;
  endfunction
  function automatic logic signed [15:0] smax(input logic signed [15:0] a, input logic signed [15:0] b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic prof_a_ok(input logic [31:0] d);
    logic ok;
    ok = 1'b1;
    if (d[2:0] > UPT_QAM128) ok = 1'b0;
    if (d[2:0] == UPT_QAM128 && !d[3]) ok = 1'b0;
    if (d[12:8] > UPT_FEC_T_MAX) ok = 1'b0;
    if (d[12:8] != 5'h00 && (d[23:16] < UPT_FEC_K_MIN || d[23:16] > UPT_FEC_K_MAX)) ok = 1'b0;
    return ok;
  endfunction

  // ==========================================================
  // next state
  logic               req;
  logic               wr;
  logic               set_rej;
  logic               clr_rej;
  logic               rescan;
  logic signed [15:0] v;
  logic signed [15:0] hi_e;
  logic signed [15:0] lo_e;
  logic signed [15:0] g;
  logic signed [15:0] tot;
  logic signed [15:0] pmx;
  upt_prof_t          p;
  upt_prof_t          gp;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.tx.start = 1'b0;
    set_rej = 1'b0;
    clr_rej = 1'b0;
    rescan = 1'b0;
    v = 16'sh0000;
    hi_e = s_r.hi;
    lo_e = s_r.lo;
    g = 16'sh0000;
    tot = 16'sh0000;
    pmx = 16'sh0000;
    p = s_r.prof[s_r.scan];
    gp = s_r.prof[s_r.gprof];

    // ========================================================
    // mini-slot tick pin
    s_nxt.tick_sync = {s_r.tick_sync[1:0], MINISLOT_TICK};
    if (s_r.tick_sync[1] == s_r.tick_sync[2] && s_r.tick_sync[2] != s_r.tick_lvl)
    begin
      s_nxt.tick_lvl = s_r.tick_sync[2];
      if (s_r.tick_sync[2]) s_nxt.slot_cnt = s_r.slot_cnt + 16'h0001;
    end

    // ========================================================
    // wishbone reads
    req = WB_REQ.cyc && WB_REQ.stb;
    wr = req && s_r.ack && WB_REQ.we && WB_REQ.sel == UPT_SEL_ALL;
    if (req && !s_r.ack)
    begin
      s_nxt.ack = 1'b1;
      if (WB_REQ.adr == UPT_OFS_CTRL) s_nxt.rdat = {27'h0, s_r.rate, s_r.spread_on, s_r.cdm};
      else if (WB_REQ.adr == UPT_OFS_CODES) s_nxt.rdat = {8'h00, s_r.alloc, s_r.cpm, s_r.active};
      else if (WB_REQ.adr == UPT_OFS_PSEL) s_nxt.rdat = {29'h0, s_r.psel};
      else if (WB_REQ.adr == UPT_OFS_PROF_A)
        s_nxt.rdat = {s_r.prof[s_r.psel].max_burst, s_r.prof[s_r.psel].fec_k, 3'h0,
                      s_r.prof[s_r.psel].fec_t, 3'h0, s_r.prof[s_r.psel].in_use,
                      s_r.prof[s_r.psel].trellis, s_r.prof[s_r.psel].mod};
      else if (WB_REQ.adr == UPT_OFS_PROF_B)
        s_nxt.rdat = {5'h00, s_r.prof[s_r.psel].pre_off, 5'h00, s_r.prof[s_r.psel].pre_len};
      else if (WB_REQ.adr == UPT_OFS_REPORT) s_nxt.rdat = {16'h0000, s_r.pr};
      else if (WB_REQ.adr == UPT_OFS_LIMITS) s_nxt.rdat = {s_r.lo, s_r.hi};
      else if (WB_REQ.adr == UPT_OFS_TARGET) s_nxt.rdat = {s_r.tx.total_pwr, s_r.tx.code_pwr};
      else if (WB_REQ.adr == UPT_OFS_GRANT) s_nxt.rdat = {5'h00, s_r.gprof, s_r.glen, s_r.gstart};
      else if (WB_REQ.adr == UPT_OFS_STATUS)
        s_nxt.rdat = {s_r.slot_cnt, 13'h0, s_r.armed, s_r.reject, s_r.fsm != UPT_IDLE};
      else if (WB_REQ.adr == UPT_OFS_SS_IDX) s_nxt.rdat = {26'h0, s_r.ss_idx};
      else if (WB_REQ.adr == UPT_OFS_SS_DATA) s_nxt.rdat = s_r.sstr[s_r.ss_idx];
      else s_nxt.rdat = 32'h0000_0000;
    end

    // ========================================================
    // wishbone writes
    if (wr)
    begin
      if (WB_REQ.adr == UPT_OFS_CTRL)
      begin
        s_nxt.cdm = WB_REQ.dat[0];
        s_nxt.spread_on = WB_REQ.dat[1];
        if (WB_REQ.dat[4:2] <= UPT_RATE_MAX) s_nxt.rate = WB_REQ.dat[4:2];
        else set_rej = 1'b1;
        rescan = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_CODES)
      begin
        if (WB_REQ.dat[7:0] == 8'h00 || WB_REQ.dat[7:0] > UPT_CODES_MAX ||
            WB_REQ.dat[15:8] == 8'h00 || WB_REQ.dat[23:16] > UPT_CODES_MAX) set_rej = 1'b1;
        else
        begin
          s_nxt.active = WB_REQ.dat[7:0];
          s_nxt.cpm = WB_REQ.dat[15:8];
          s_nxt.alloc = WB_REQ.dat[23:16];
          rescan = 1'b1;
        end
      end
      else if (WB_REQ.adr == UPT_OFS_PSEL) s_nxt.psel = WB_REQ.dat[2:0];
      else if (WB_REQ.adr == UPT_OFS_PROF_A)
      begin
        if (prof_a_ok(WB_REQ.dat))
        begin
          s_nxt.prof[s_r.psel].mod = WB_REQ.dat[2:0];
          s_nxt.prof[s_r.psel].trellis = WB_REQ.dat[3];
          s_nxt.prof[s_r.psel].in_use = WB_REQ.dat[4];
          s_nxt.prof[s_r.psel].fec_t = WB_REQ.dat[12:8];
          s_nxt.prof[s_r.psel].fec_k = WB_REQ.dat[23:16];
          s_nxt.prof[s_r.psel].max_burst = WB_REQ.dat[31:24];
          rescan = 1'b1;
        end
        else set_rej = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_PROF_B)
      begin
        if (WB_REQ.dat[10:0] <= UPT_PRE_LEN_MAX && WB_REQ.dat[26:16] <= UPT_PRE_OFF_MAX)
        begin
          s_nxt.prof[s_r.psel].pre_len = WB_REQ.dat[10:0];
          s_nxt.prof[s_r.psel].pre_off = WB_REQ.dat[26:16];
        end
        else set_rej = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_ADJ)
      begin
        if (s_r.fsm != UPT_IDLE) set_rej = 1'b1;
        else
        begin
          s_nxt.step = step_in;
          rescan = 1'b1;
        end
      end
      else if (WB_REQ.adr == UPT_OFS_REPORT)
      begin
        s_nxt.pr = WB_REQ.dat[15:0];
        s_nxt.step = 16'sh0000;
        rescan = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_GRANT)
      begin
        if (s_r.prof[WB_REQ.dat[26:24]].in_use)
        begin
          s_nxt.gstart = WB_REQ.dat[15:0];
          s_nxt.glen = WB_REQ.dat[23:16];
          s_nxt.gprof = WB_REQ.dat[26:24];
          s_nxt.armed = 1'b1;
        end
        else set_rej = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_STATUS) clr_rej = WB_REQ.dat[1];
      else if (WB_REQ.adr == UPT_OFS_SS_IDX)
      begin
        if (WB_REQ.dat[5:0] <= UPT_SS_IDX_LAST) s_nxt.ss_idx = WB_REQ.dat[5:0];
        else set_rej = 1'b1;
      end
      else if (WB_REQ.adr == UPT_OFS_SS_DATA) s_nxt.sstr[s_r.ss_idx] = WB_REQ.dat;
    end

    // ========================================================
    // limit scan and reported power update
    case (s_r.fsm)
      UPT_IDLE: ;
      UPT_SCAN:
      begin
        if (p.in_use)
        begin
          g = upt_gain(p.mod);
          s_nxt.hi = smin(s_r.hi, 16'(upt_pmax(s_r.cdm, p.mod) - g));
          s_nxt.lo = smax(s_r.lo, 16'(UPT_PMIN - g));
          s_nxt.found = 1'b1;
        end
        s_nxt.scan = 3'(s_r.scan + 3'h1);
        if (s_r.scan == 3'(UPT_NPROF - 1)) s_nxt.fsm = UPT_APPLY;
      end
      UPT_APPLY:
      begin
        if (!s_r.found)
        begin
          hi_e = upt_pmax(s_r.cdm, UPT_QAM64);
          lo_e = UPT_PMIN;
        end
        if (s_r.cdm) lo_e = 16'(lo_e + $signed(l_act) - $signed(l_cpm));
        v = 16'(s_r.pr + s_r.step);
        v = smin(v, hi_e);
        v = smax(v, lo_e);
        s_nxt.pr = v;
        s_nxt.hi = hi_e;
        s_nxt.lo = lo_e;
        s_nxt.step = 16'sh0000;
        s_nxt.fsm = UPT_IDLE;
      end
      default: s_nxt.fsm = UPT_IDLE;
    endcase
    if (rescan)
    begin
      s_nxt.fsm = UPT_SCAN;
      s_nxt.scan = 3'h0;
      s_nxt.found = 1'b0;
      s_nxt.hi = UPT_LIM_HI_INIT;
      s_nxt.lo = UPT_LIM_LO_INIT;
    end

    // ========================================================
    // burst start at granted mini-slot
    if (s_r.armed && s_r.slot_cnt == s_r.gstart)
    begin
      g = upt_gain(gp.mod);
      pmx = upt_pmax(s_r.cdm, gp.mod);
      s_nxt.armed = 1'b0;
      s_nxt.tx.start = 1'b1;
      s_nxt.tx.profile = s_r.gprof;
      s_nxt.tx.rate = s_r.rate;
      if (gp.max_burst == 8'h00 || s_r.glen < gp.max_burst) s_nxt.tx.len = s_r.glen;
      else s_nxt.tx.len = gp.max_burst;
      if (s_r.cdm && s_r.spread_on)
      begin
        tot = 16'(s_r.pr + g - $signed(l_act) + $signed(l_alc));
        tot = smax(smin(tot, pmx), UPT_PMIN);
        s_nxt.tx.total_pwr = tot;
        s_nxt.tx.code_pwr = 16'(tot - $signed(l_alc));
      end
      else
      begin
        tot = 16'(s_r.pr + g);
        tot = smax(smin(tot, pmx), UPT_PMIN);
        s_nxt.tx.total_pwr = tot;
        s_nxt.tx.code_pwr = tot;
      end
    end

    // reject flag: a new event wins over the clear
    s_nxt.reject = (s_r.reject && !clr_rej) || set_rej;
  end

  // ==========================================================
  // registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_r <= '0;
      s_r.pr <= UPT_PR_RST;
      s_r.active <= 8'h01;
      s_r.cpm <= 8'h01;
      s_r.hi <= UPT_PMAX_CDM;
      s_r.lo <= UPT_PMIN;
      s_r.fsm <= UPT_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign WB_RSP.ack = s_r.ack;
  assign WB_RSP.dat = s_r.rdat;
  assign TX_BURST = s_r.tx;
endmodule // upt_top

// ===== tb/upt_headend_model.sv
// head-end mini-slot tick source
// assumes the modem clock; one slot every 32 clocks
`timescale 1ns/1ps
module upt_headend_model
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [4:0] cnt_r;
  // ==========================================================
  // slot timing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 5'h00;
    else
      cnt_r <= cnt_r + 5'h01;
  end
  assign tick = (cnt_r >= 5'h18);
endmodule // upt_headend_model

// ===== tb/upt_top_checker.sv
// assertions on the upt_top ports
// assumes one clock and one reset, bound to upt_top
`timescale 1ns/1ps
module upt_top_checker
(
  input wire logic                 REF_CLK,
  input wire logic                 RST_N,
  input wire upt_pkg::upt_wb_req_t WB_REQ,
  input wire upt_pkg::upt_wb_rsp_t WB_RSP,
  input wire logic                 MINISLOT_TICK,
  input wire upt_pkg::upt_tx_t     TX_BURST
);
  import upt_pkg::*;
  logic spr_r;
  logic spr_nxt;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // spreader flag as last written
  always_comb
  begin
    spr_nxt = spr_r;
    if (WB_RSP.ack && WB_REQ.we && WB_REQ.sel == UPT_SEL_ALL && WB_REQ.adr == UPT_OFS_CTRL)
      spr_nxt = WB_REQ.dat[1];
  end
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      spr_r <= 1'b0;
    else
      spr_r <= spr_nxt;
  end
  // ==========================================================
  // bus handshake
  property p_ack_answer;
    WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
  property p_ack_once;
    WB_RSP.ack |=> !WB_RSP.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_unmapped;
    WB_RSP.ack && !WB_REQ.we && WB_REQ.adr >= 8'h34 |-> WB_RSP.dat == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ==========================================================
  // burst output
  property p_start_pulse;
    TX_BURST.start |=> !TX_BURST.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_hold;
    !TX_BURST.start |-> $stable({TX_BURST.len, TX_BURST.code_pwr, TX_BURST.total_pwr});
  endproperty
  a_hold: assert property (p_hold) else $error("burst fields moved without start");
  property p_rate;
    TX_BURST.start |-> TX_BURST.rate <= UPT_RATE_MAX;
  endproperty
  a_rate: assert property (p_rate) else $error("rate code out of range");
  property p_range;
    TX_BURST.start |-> TX_BURST.total_pwr >= UPT_PMIN && TX_BURST.total_pwr <= UPT_PMAX_QPSK;
  endproperty
  a_range: assert property (p_range) else $error("target power out of limits");
  property p_sum;
    TX_BURST.start |-> TX_BURST.code_pwr <= TX_BURST.total_pwr;
  endproperty
  a_sum: assert property (p_sum) else $error("code power above frame total");
  property p_flat;
    TX_BURST.start && !spr_r |-> TX_BURST.code_pwr == TX_BURST.total_pwr;
  endproperty
  a_flat: assert property (p_flat) else $error("unspread code and total differ");
  c_write: cover property (WB_RSP.ack && WB_REQ.we);
  c_spread: cover property (TX_BURST.start && spr_r);
  c_flat: cover property (TX_BURST.start && !spr_r);
endmodule // upt_top_checker

bind upt_top upt_top_checker i_upt_top_checker
(
  .REF_CLK       (REF_CLK),
  .RST_N         (RST_N),
  .WB_REQ        (WB_REQ),
  .WB_RSP        (WB_RSP),
  .MINISLOT_TICK (MINISLOT_TICK),
  .TX_BURST      (TX_BURST)
);

// ===== tb/upt_top_test.sv
// self-checking bench for upt_top
// assumes the head-end model supplies mini-slot ticks
`timescale 1ns/1ps
module upt_top_test;
  import upt_pkg::*;
  typedef struct packed {
    logic [7:0] adr; logic [31:0] dat; logic [7:0] cadr; logic [31:0] mask; logic [31:0] exp;
  } upt_row_t;
  logic        ref_clk;
  logic        rst_n;
  logic        tick;
  upt_wb_req_t req;
  upt_wb_rsp_t rsp;
  upt_tx_t     tx;
  logic [31:0] rd;
  int          miscompares;
  int          n_tests;
  upt_row_t    rows [$] = '{
    '{8'h00, 32'h1, 8'h1C, 32'hFFFFFFFF, 32'h1A902C24}, '{8'h18, 32'h2EE0, 8'h18, 32'hFFFF, 32'h2C24},
    '{8'h18, 32'h2328, 8'h18, 32'hFFFF, 32'h2328}, '{8'h14, 32'h4, 8'h18, 32'hFFFF, 32'h238C},
    '{8'h14, 32'h2, 8'h18, 32'hFFFF, 32'h238C}, '{8'h14, 32'h3, 8'h18, 32'hFFFF, 32'h23F0},
    '{8'h14, 32'h6, 8'h18, 32'hFFFF, 32'h2454}, '{8'h14, 32'hFA, 8'h18, 32'hFFFF, 32'h23F0},
    '{8'h14, 32'hFD, 8'h18, 32'hFFFF, 32'h238C}, '{8'h14, 32'h7F, 8'h18, 32'hFFFF, 32'h2C24},
    '{8'h14, 32'h80, 8'h18, 32'hFFFF, 32'h1FA4}, '{8'h14, 32'h80, 8'h18, 32'hFFFF, 32'h1A90},
    '{8'h08, 32'h1, 8'h28, 32'h2, 32'h0}, '{8'h0C, 32'h5, 8'h28, 32'h2, 32'h2},
    '{8'h0C, 32'hD, 8'h28, 32'h2, 32'h0}, '{8'h0C, 32'hFD1001, 8'h28, 32'h2, 32'h0},
    '{8'h0C, 32'h101102, 8'h28, 32'h2, 32'h2}, '{8'h0C, 32'hF0103, 8'h28, 32'h2, 32'h2},
    '{8'h0C, 32'hFF100004, 8'h28, 32'h2, 32'h0}, '{8'h10, 32'h5FE0600, 8'h28, 32'h2, 32'h0},
    '{8'h10, 32'h601, 8'h28, 32'h2, 32'h2}, '{8'h00, 32'h19, 8'h28, 32'h2, 32'h2},
    '{8'h00, 32'h15, 8'h28, 32'h2, 32'h0}, '{8'h2C, 32'h2F, 8'h28, 32'h2, 32'h0},
    '{8'h30, 32'hA5C30F1E, 8'h30, 32'hFFFFFFFF, 32'hA5C30F1E}, '{8'h40, 32'hFF, 8'h40, 32'hFFFFFFFF, 32'h0},
    '{8'h04, 32'h20104, 8'h1C, 32'hFFFFFFFF, 32'h1CEA2C24}, '{8'h08, 32'h0, 8'h28, 32'h2, 32'h0},
    '{8'h0C, 32'h100010, 8'h1C, 32'hFFFFFFFF, 32'h1D602C9A}, '{8'h40, 32'h0, 8'h18, 32'hFFFF, 32'h1D60}};

  upt_top i_upt_top (.REF_CLK(ref_clk), .RST_N(rst_n), .WB_REQ(req), .WB_RSP(rsp), .MINISLOT_TICK(tick),
    .TX_BURST(tx));
  upt_headend_model i_upt_headend_model (.clk(ref_clk), .rst_n(rst_n), .tick(tick));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // bus and check tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail();
    miscompares++;
    $display("ERROR t=%0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int i;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    @(posedge ref_clk);
    for (i = 0; i < 20 && rsp.ack !== 1'b1; i++)
      @(posedge ref_clk);
    if (rsp.ack !== 1'b1)
      fail();
    q = rsp.dat;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    int i;
    logic [31:0] q;
    wb(1'b1, adr, dat, q);
    for (i = 0; i < 40; i++)
    begin
      wb(1'b0, UPT_OFS_STATUS, 32'h0, q);
      if (q[0] === 1'b0)
        break;
    end
    if (q[0] !== 1'b0)
      fail();
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_tx(input upt_tx_t exp);
    n_tests++;
    if (tx !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t burst got %h exp %h", $time, tx, exp);
    end
  endtask
  task automatic burst(input logic [7:0] glen, input logic [7:0] elen, input logic [15:0] ec,
                       input logic [15:0] et);
    int i;
    wb(1'b0, UPT_OFS_STATUS, 32'h0, rd);
    wr(UPT_OFS_GRANT, {8'h00, glen, rd[31:16] + 16'h0002});
    for (i = 0; i < 400 && tx.start !== 1'b1; i++)
      @(posedge ref_clk);
    if (tx.start !== 1'b1)
      fail();
    chk_tx('{1'b1, 3'h0, 3'h5, elen, ec, et});
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(1'b0, UPT_OFS_REPORT, 32'h0, rd);
    chk32(rd & 32'hFFFF, 32'h2328);
    chk_tx('0);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    miscompares = 0;
    n_tests = 0;
    do_reset();
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(UPT_OFS_STATUS, 32'h2);
      wr(rows[i].adr, rows[i].dat);
      wb(1'b0, rows[i].cadr, 32'h0, rd);
      chk32(rd & rows[i].mask, rows[i].exp);
    end
    $display("test table done");
    burst(8'h05, 8'h05, 16'h1CEA, 16'h1CEA);
    wr(UPT_OFS_CTRL, 32'h17);
    burst(8'h05, 8'h05, 16'h1A90, 16'h1BBD);
    wr(UPT_OFS_PROF_A, 32'h03100010);
    burst(8'h05, 8'h03, 16'h1A90, 16'h1BBD);
    $display("test bursts done");
    wr(UPT_OFS_STATUS, 32'h2);
    wb(1'b1, UPT_OFS_ADJ, 32'h4, rd);
    wr(UPT_OFS_ADJ, 32'h4);
    wb(1'b0, UPT_OFS_REPORT, 32'h0, rd);
    chk32(rd & 32'hFFFF, 32'h1DC4);
    wb(1'b0, UPT_OFS_STATUS, 32'h0, rd);
    chk32(rd & 32'h2, 32'h2);
    $display("test busy refusal done");
    do_reset();
    $display("test second reset done");
    report_and_stop();
  end
endmodule // upt_top_test
